// File: pasm_pkg.sv
package pasm_pkg;

   localparam int COMP_W = 32;
   localparam int VTX_W = 4 * COMP_W;
   localparam int X_POS = 0;
   localparam int Y_POS = 32;
   localparam int Z_POS = 64;
   localparam int W_POS = 96;

   localparam int ATTR_SLOT_COUNT = 16;
   localparam int SLOT_W = 4;
   localparam int ATTR_IDX_W = 8;

   localparam logic [COMP_W-1:0] FLOAT_ZERO = 32'h0000_0000;
   localparam logic [COMP_W-1:0] FLOAT_ONE = 32'h3f80_0000;

   // Component count field holds count minus one
   localparam logic [1:0] NCOMP_TWO = 2'h1;
   localparam logic [1:0] NCOMP_THREE = 2'h2;
   localparam logic [1:0] NCOMP_FOUR = 2'h3;

   localparam logic [1:0] ERR_NONE = 2'h0;
   localparam logic [1:0] ERR_BAD_VALUE = 2'h1;

   typedef logic [VTX_W-1:0] pasm_vtx_type;

   localparam pasm_vtx_type ATTR_DEFAULT =
      {FLOAT_ONE, FLOAT_ZERO, FLOAT_ZERO, FLOAT_ZERO};

   typedef enum logic [2:0] {
      MODE_SINGLE_DOTS,
      MODE_CONNECTED_SEGMENTS,
      MODE_CLOSED_SEGMENTS,
      MODE_SEGMENT_PAIRS,
      MODE_TRI_CHAIN,
      MODE_TRI_PIVOT,
      MODE_TRI_GROUPS
   } pasm_mode_type;

   typedef enum logic [1:0] {
      KIND_POINT,
      KIND_SEGMENT,
      KIND_TRIANGLE
   } pasm_kind_type;

   typedef struct packed {
      pasm_kind_type kind;
      logic poly;
      pasm_vtx_type v0;
      pasm_vtx_type v1;
      pasm_vtx_type v2;
   } pasm_prim_type;

endpackage

// File: pasm_prim_if.sv
`timescale 1ns/1ps
`default_nettype none
interface pasm_prim_if;
   import pasm_pkg::*;
   logic valid;
   logic ready;
   pasm_prim_type data;
   modport prod (output valid, output data, input ready);
   modport cons (input valid, input data, output ready);
endinterface
`default_nettype wire

// File: pasm_buf.sv
`timescale 1ns/1ps
`default_nettype none
module pasm_buf
   import pasm_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic reset_i,
   pasm_prim_if.cons push,
   pasm_prim_if.prod pop
);
   localparam logic [1:0] DEPTH = 2'h2;

   typedef struct packed {
      pasm_prim_type e0;
      pasm_prim_type e1;
      logic [1:0] cnt;
   } pasm_buf_type;

   pasm_buf_type s_q;
   pasm_buf_type s_d;
   logic do_push;
   logic do_pop;

   // Head always sits in e0, so the output comes straight from a flop
   assign push.ready = (s_q.cnt != DEPTH);
   assign pop.valid = (s_q.cnt != 2'h0);
   assign pop.data = s_q.e0;
   assign do_push = push.valid && push.ready;
   assign do_pop = pop.valid && pop.ready;

   always_comb
   begin
      s_d = s_q;
      if (do_pop)
      begin
         s_d.e0 = s_q.e1;
         s_d.cnt = s_q.cnt - 2'h1;
      end
      if (do_push)
      begin
         if (s_d.cnt == 2'h0)
            s_d.e0 = push.data;
         else
            s_d.e1 = push.data;
         s_d.cnt = s_d.cnt + 2'h1;
      end
   end

   always_ff @(posedge sys_clk_i or posedge reset_i)
   begin
      if (reset_i)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   a_buf_full_stall: assert property (@(posedge sys_clk_i) disable iff
      (reset_i) (s_q.cnt == DEPTH && !pop.ready) |=> $stable(s_q.e1))
      else $error("buffer accepts while full");
   a_buf_first_out: assert property (@(posedge sys_clk_i) disable iff
      (reset_i) (do_push && s_q.cnt == 2'h0)
      |=> (pop.valid && pop.data == $past(push.data)))
      else $error("word into empty buffer not at head");
   a_buf_hold_head: assert property (@(posedge sys_clk_i) disable iff
      (reset_i) (pop.valid && !pop.ready) |=>
      (pop.valid && $stable(pop.data)))
      else $error("stalled head changed");
endmodule
`default_nettype wire

// File: pasm_top.sv
`timescale 1ns/1ps
`default_nettype none
module pasm_top
   import pasm_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic reset_i,
   input wire logic draw_start_i,
   input wire pasm_mode_type draw_mode_i,
   input wire logic vtx_valid_i,
   input wire logic vtx_last_i,
   input wire pasm_vtx_type vtx_data_i,
   output logic vtx_ready_o,
   output logic prim_valid_o,
   input wire logic prim_ready_i,
   output pasm_kind_type prim_kind_o,
   output logic prim_poly_o,
   output pasm_vtx_type prim_v0_o,
   output pasm_vtx_type prim_v1_o,
   output pasm_vtx_type prim_v2_o,
   input wire logic attr_wr_i,
   input wire logic attr_int_i,
   input wire logic [1:0] attr_ncomp_i,
   input wire logic [ATTR_IDX_W-1:0] attr_slot_i,
   input wire logic [1:0] attr_col_i,
   input wire pasm_vtx_type attr_data_i,
   input wire logic [ATTR_IDX_W-1:0] attr_rd_slot_i,
   input wire logic attr_array_en_i,
   input wire pasm_vtx_type attr_array_data_i,
   output pasm_vtx_type attr_rd_data_o,
   input wire logic err_clear_i,
   output logic err_flag_o,
   output logic [1:0] err_code_o
);
   typedef struct packed {
      logic first;
      logic parity;
      logic tri_done;
      logic ptr;
      logic [1:0] nstored;
      logic [1:0] grp;
      logic close_pend;
      pasm_vtx_type va;
      pasm_vtx_type vb;
      pasm_vtx_type vprev;
      pasm_vtx_type vfirst;
      logic err_flag;
      logic [1:0] err_code;
      pasm_vtx_type rd_data;
      pasm_vtx_type [ATTR_SLOT_COUNT-1:0] mem;
   } pasm_state_type;

   localparam logic [1:0] FULL_PAIR = 2'h2;
   localparam logic [1:0] GRP_A = 2'h0;
   localparam logic [1:0] GRP_B = 2'h1;
   localparam logic [1:0] GRP_C = 2'h2;

   pasm_state_type s_q;
   pasm_state_type s_d;
   pasm_prim_if pi ();
   pasm_prim_if po ();

   logic acc;
   logic [ATTR_IDX_W:0] eff_slot;
   logic bad_wr;
   logic good_wr;

   function automatic pasm_prim_type mk_prim(pasm_kind_type k,
      pasm_vtx_type a, pasm_vtx_type b, pasm_vtx_type c);
      pasm_prim_type p;
      p.kind = k;
      p.poly = (k == KIND_TRIANGLE);
      p.v0 = a;
      p.v1 = b;
      p.v2 = c;
      return p;
   endfunction

   function automatic pasm_vtx_type fill_float(pasm_vtx_type v,
      logic [1:0] n);
      pasm_vtx_type r;
      r = v;
      if (n < NCOMP_FOUR)
         r[W_POS +: COMP_W] = FLOAT_ONE;
      if (n < NCOMP_THREE)
         r[Z_POS +: COMP_W] = FLOAT_ZERO;
      if (n < NCOMP_TWO)
         r[Y_POS +: COMP_W] = FLOAT_ZERO;
      return r;
   endfunction

   pasm_buf u_buf (
      .sys_clk_i (sys_clk_i),
      .reset_i (reset_i),
      .push (pi.cons),
      .pop (po.prod)
   );

   // Stall on any vertex when the buffer is full, even non-emitting ones;
   // costs a cycle now and then but keeps the accept path simple
   assign vtx_ready_o = pi.ready && !s_q.close_pend && !draw_start_i;
   assign acc = vtx_valid_i && vtx_ready_o;
   assign po.ready = prim_ready_i;
   assign prim_valid_o = po.valid;
   assign prim_kind_o = po.data.kind;
   assign prim_poly_o = po.data.poly;
   assign prim_v0_o = po.data.v0;
   assign prim_v1_o = po.data.v1;
   assign prim_v2_o = po.data.v2;
   assign attr_rd_data_o = s_q.rd_data;
   assign err_flag_o = s_q.err_flag;
   assign err_code_o = s_q.err_code;

   // Matrix columns land in consecutive slots from the base index
   assign eff_slot = {1'b0, attr_slot_i} + {{(ATTR_IDX_W-1){1'b0}},
      attr_col_i};
   assign bad_wr = attr_wr_i && (eff_slot >= ATTR_SLOT_COUNT);
   assign good_wr = attr_wr_i && !bad_wr;

   always_comb
   begin
      s_d = s_q;
      pi.valid = 1'b0;
      pi.data = '0;
      if (draw_start_i)
      begin
         s_d.first = 1'b1;
         s_d.parity = 1'b0;
         s_d.tri_done = 1'b0;
         s_d.ptr = 1'b0;
         s_d.nstored = 2'h0;
         s_d.grp = GRP_A;
         s_d.close_pend = 1'b0;
         s_d.va = '0;
         s_d.vb = '0;
         s_d.vprev = '0;
         s_d.vfirst = '0;
      end
      else if (s_q.close_pend)
      begin
         pi.valid = 1'b1;
         pi.data = mk_prim(KIND_SEGMENT, s_q.vprev, s_q.vfirst, '0);
         if (pi.ready)
            s_d.close_pend = 1'b0;
      end
      else if (acc)
      begin
         // No counter bounds a draw: state is per vertex only
         case (draw_mode_i)
            MODE_SINGLE_DOTS:
            begin
               pi.valid = 1'b1;
               pi.data = mk_prim(KIND_POINT, vtx_data_i, '0, '0);
            end
            MODE_CONNECTED_SEGMENTS, MODE_CLOSED_SEGMENTS:
            begin
               if (!s_q.first)
               begin
                  pi.valid = 1'b1;
                  pi.data = mk_prim(KIND_SEGMENT, s_q.vprev, vtx_data_i,
                     '0);
               end
               if (s_q.first)
                  s_d.vfirst = vtx_data_i;
               s_d.vprev = vtx_data_i;
               s_d.first = 1'b0;
               // A lone vertex closes nothing
               if (draw_mode_i == MODE_CLOSED_SEGMENTS && vtx_last_i &&
                  !s_q.first)
                  s_d.close_pend = 1'b1;
            end
            MODE_SEGMENT_PAIRS:
            begin
               if (s_q.parity)
               begin
                  pi.valid = 1'b1;
                  pi.data = mk_prim(KIND_SEGMENT, s_q.va, vtx_data_i, '0);
               end
               else
                  s_d.va = vtx_data_i;
               s_d.parity = !s_q.parity;
               s_d.first = 1'b0;
            end
            MODE_TRI_CHAIN, MODE_TRI_PIVOT:
            begin
               if (s_q.nstored == FULL_PAIR)
               begin
                  pi.valid = 1'b1;
                  pi.data = mk_prim(KIND_TRIANGLE, s_q.va, s_q.vb,
                     vtx_data_i);
                  s_d.tri_done = 1'b1;
               end
               else
                  s_d.nstored = s_q.nstored + 2'h1;
               if (draw_mode_i == MODE_TRI_PIVOT)
               begin
                  if (s_q.first)
                     s_d.va = vtx_data_i;
                  else
                     s_d.vb = vtx_data_i;
               end
               else if (!s_q.ptr)
                  s_d.va = vtx_data_i;
               else
                  s_d.vb = vtx_data_i;
               s_d.ptr = !s_q.ptr;
               s_d.first = 1'b0;
            end
            MODE_TRI_GROUPS:
            begin
               case (s_q.grp)
                  GRP_A:
                  begin
                     s_d.va = vtx_data_i;
                     s_d.grp = GRP_B;
                  end
                  GRP_B:
                  begin
                     s_d.vb = vtx_data_i;
                     s_d.grp = GRP_C;
                  end
                  default:
                  begin
                     pi.valid = 1'b1;
                     pi.data = mk_prim(KIND_TRIANGLE, s_q.va, s_q.vb,
                        vtx_data_i);
                     s_d.tri_done = 1'b1;
                     s_d.grp = GRP_A;
                  end
               endcase
               s_d.first = 1'b0;
            end
            default:
            begin
               s_d.first = s_q.first;
            end
         endcase
      end

      // Clear counts as the read; a coincident new error still latches
      if (err_clear_i)
      begin
         s_d.err_flag = 1'b0;
         s_d.err_code = ERR_NONE;
      end
      if (bad_wr)
      begin
         if (!s_q.err_flag || err_clear_i)
            s_d.err_code = ERR_BAD_VALUE;
         s_d.err_flag = 1'b1;
      end
      // Bad writes fall through without touching the store
      if (good_wr)
      begin
         if (attr_int_i)
            s_d.mem[eff_slot[SLOT_W-1:0]] = attr_data_i;
         else
            s_d.mem[eff_slot[SLOT_W-1:0]] =
               fill_float(attr_data_i, attr_ncomp_i);
      end

      if (attr_array_en_i)
         s_d.rd_data = attr_array_data_i;
      else if (attr_rd_slot_i < ATTR_SLOT_COUNT)
         s_d.rd_data = s_q.mem[attr_rd_slot_i[SLOT_W-1:0]];
      else
         s_d.rd_data = ATTR_DEFAULT;
   end

   always_ff @(posedge sys_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         s_q <= '0;
         s_q.first <= 1'b1;
         s_q.rd_data <= ATTR_DEFAULT;
         s_q.mem <= {ATTR_SLOT_COUNT{ATTR_DEFAULT}};
      end
      else
         s_q <= s_d;
   end

   default clocking @(posedge sys_clk_i);
   endclocking
   default disable iff (reset_i);

   sequence s_close_out;
      pi.valid && pi.data.kind == KIND_SEGMENT &&
         pi.data.v0 == s_q.vprev && pi.data.v1 == s_q.vfirst;
   endsequence

   sequence s_close_done;
      !s_q.close_pend && s_q.vfirst == $past(s_q.vfirst);
   endsequence

   a_dot_per_vertex: assert property (
      (acc && draw_mode_i == MODE_SINGLE_DOTS) |->
      (pi.valid && pi.data.kind == KIND_POINT && pi.data.v0 == vtx_data_i))
      else $error("vertex in dots mode gave no point");

   a_strip_segment: assert property (
      (acc && draw_mode_i == MODE_CONNECTED_SEGMENTS && !s_q.first) |->
      (pi.valid && pi.data.v0 == s_q.vprev && pi.data.v1 == vtx_data_i))
      else $error("connected segment wrong");

   a_strip_first_silent: assert property (
      (acc && draw_mode_i == MODE_CONNECTED_SEGMENTS && s_q.first) |->
      (!pi.valid ##1 (s_q.vprev == $past(vtx_data_i) && !s_q.first)))
      else $error("first vertex emitted a segment");

   a_loop_close: assert property (
      (acc && draw_mode_i == MODE_CLOSED_SEGMENTS && vtx_last_i &&
      !s_q.first) |=> (s_q.close_pend && !vtx_ready_o))
      else $error("closing segment not scheduled");

   a_loop_close_out: assert property (
      (s_q.close_pend && pi.ready && !draw_start_i) |->
      (s_close_out ##1 s_close_done))
      else $error("closing segment wrong");

   a_pair_odd_drop: assert property (
      (acc && draw_mode_i == MODE_SEGMENT_PAIRS && !s_q.parity) |->
      (!pi.valid ##1 (s_q.parity && s_q.va == $past(vtx_data_i))))
      else $error("segment start mishandled");

   a_tri_order: assert property (
      (acc && draw_mode_i == MODE_TRI_CHAIN && s_q.nstored == FULL_PAIR)
      |-> (pi.valid && pi.data.v0 == s_q.va && pi.data.v1 == s_q.vb &&
      pi.data.v2 == vtx_data_i) ##1 s_q.tri_done)
      else $error("triangle order wrong");

   a_chain_short: assert property (
      (acc && draw_mode_i == MODE_TRI_CHAIN && s_q.nstored != FULL_PAIR)
      |-> !pi.valid)
      else $error("triangle before third vertex");

   a_pivot_keeps_a: assert property (
      (acc && draw_mode_i == MODE_TRI_PIVOT && !s_q.first) |=>
      (s_q.va == $past(s_q.va) && s_q.vb == $past(vtx_data_i)))
      else $error("pivot vertex replaced");

   a_group_third: assert property (
      (acc && draw_mode_i == MODE_TRI_GROUPS && s_q.grp != GRP_C) |->
      !pi.valid)
      else $error("group emitted early");

   a_poly_class: assert property (
      pi.valid |-> (pi.data.poly == (draw_mode_i inside {MODE_TRI_CHAIN,
      MODE_TRI_PIVOT, MODE_TRI_GROUPS}))) else $error("polygon class wrong");

   a_bad_slot_err: assert property (
      (bad_wr && !s_q.err_flag) |=>
      (s_q.err_flag && s_q.err_code == ERR_BAD_VALUE))
      else $error("bad slot did not raise error");

   a_bad_discard: assert property (
      (bad_wr && !good_wr) |=> (s_q.mem == $past(s_q.mem)))
      else $error("bad write changed store");

   a_err_sticky: assert property (
      (s_q.err_flag && !err_clear_i) |=>
      (s_q.err_flag && s_q.err_code == $past(s_q.err_code)))
      else $error("latched error lost");

   a_fill_short: assert property (
      (good_wr && !attr_int_i && attr_ncomp_i == 2'h0) |=>
      (s_q.mem[$past(eff_slot[SLOT_W-1:0])][W_POS +: COMP_W] == FLOAT_ONE
      && s_q.mem[$past(eff_slot[SLOT_W-1:0])][Y_POS +: COMP_W] ==
      FLOAT_ZERO))
      else $error("short float write not filled");

   a_int_raw: assert property (
      (good_wr && attr_int_i) |=>
      (s_q.mem[$past(eff_slot[SLOT_W-1:0])] == $past(attr_data_i)))
      else $error("integer write altered");

   a_start_clear: assert property (
      draw_start_i |=> (s_q.first && s_q.nstored == 2'h0 && !s_q.ptr &&
      !s_q.parity && !s_q.tri_done && s_q.grp == GRP_A))
      else $error("draw start left state");
endmodule
`default_nettype wire

// File: pasm_sink_model.sv
`timescale 1ns/1ps
`default_nettype none
module pasm_sink_model
   import pasm_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic reset_i,
   input wire logic hold_i,
   input wire logic prim_valid_i,
   input wire pasm_kind_type prim_kind_i,
   input wire logic prim_poly_i,
   input wire pasm_vtx_type prim_v0_i,
   input wire pasm_vtx_type prim_v1_i,
   input wire pasm_vtx_type prim_v2_i,
   output logic prim_ready_o
);
   pasm_prim_type got_q[$];
   // Random stalls so the two-entry buffer fills and drains
   always @(posedge sys_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         prim_ready_o <= 1'b0;
      end
      else
      begin
         if (prim_valid_i && prim_ready_o)
         begin
            got_q.push_back({prim_kind_i, prim_poly_i, prim_v0_i, prim_v1_i,
               prim_v2_i});
         end
         prim_ready_o <= !hold_i && ($urandom_range(3) != 0);
      end
   end
endmodule
`default_nettype wire

// File: tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import pasm_pkg::*;
   logic sys_clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic draw_start_i = 1'b0;
   pasm_mode_type draw_mode_i = MODE_SINGLE_DOTS;
   logic vtx_valid_i = 1'b0;
   logic vtx_last_i = 1'b0;
   pasm_vtx_type vtx_data_i = '0;
   logic vtx_ready_o, prim_valid_o, prim_ready_i, prim_poly_o, err_flag_o;
   logic hold = 1'b0;
   pasm_kind_type prim_kind_o;
   pasm_vtx_type prim_v0_o, prim_v1_o, prim_v2_o, attr_rd_data_o;
   logic attr_wr_i = 1'b0;
   logic attr_int_i = 1'b0;
   logic [1:0] attr_ncomp_i = 2'h0;
   logic [1:0] attr_col_i = 2'h0;
   logic [ATTR_IDX_W-1:0] attr_slot_i = '0;
   logic [ATTR_IDX_W-1:0] attr_rd_slot_i = '0;
   pasm_vtx_type attr_data_i = '0;
   pasm_vtx_type attr_array_data_i = '0;
   logic attr_array_en_i = 1'b0;
   logic err_clear_i = 1'b0;
   logic [1:0] err_code_o;
   int err_total = 0;
   int check_count = 0;
   int seed;
   pasm_prim_type exp_q[$];
   pasm_vtx_type vq[$];
   pasm_vtx_type mem[16];

   always #2.5 sys_clk_i = !sys_clk_i;

   pasm_top i_dut (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
      .draw_start_i(draw_start_i), .draw_mode_i(draw_mode_i),
      .vtx_valid_i(vtx_valid_i), .vtx_last_i(vtx_last_i),
      .vtx_data_i(vtx_data_i), .vtx_ready_o(vtx_ready_o),
      .prim_valid_o(prim_valid_o), .prim_ready_i(prim_ready_i),
      .prim_kind_o(prim_kind_o), .prim_poly_o(prim_poly_o),
      .prim_v0_o(prim_v0_o), .prim_v1_o(prim_v1_o), .prim_v2_o(prim_v2_o),
      .attr_wr_i(attr_wr_i), .attr_int_i(attr_int_i),
      .attr_ncomp_i(attr_ncomp_i), .attr_slot_i(attr_slot_i),
      .attr_col_i(attr_col_i), .attr_data_i(attr_data_i),
      .attr_rd_slot_i(attr_rd_slot_i), .attr_array_en_i(attr_array_en_i),
      .attr_array_data_i(attr_array_data_i), .attr_rd_data_o(attr_rd_data_o),
      .err_clear_i(err_clear_i), .err_flag_o(err_flag_o),
      .err_code_o(err_code_o));

   pasm_sink_model i_sink (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
      .hold_i(hold), .prim_valid_i(prim_valid_o), .prim_kind_i(prim_kind_o),
      .prim_poly_i(prim_poly_o), .prim_v0_i(prim_v0_o),
      .prim_v1_i(prim_v1_o), .prim_v2_i(prim_v2_o),
      .prim_ready_o(prim_ready_i));

   task automatic final_report();
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic chk(input logic [399:0] g, input logic [399:0] e);
      check_count++;
      if (g !== e)
      begin
         err_total++;
         $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
      end
   endtask

   task automatic timeout();
      err_total++;
      $display("[FAIL] t=%0t wait ran out", $time);
      final_report();
   endtask

   function automatic pasm_prim_type mk(input pasm_kind_type k,
      input pasm_vtx_type a, input pasm_vtx_type b, input pasm_vtx_type c);
      return {k, k == KIND_TRIANGLE, a, b, c};
   endfunction

   task automatic build(input logic [2:0] m);
      pasm_vtx_type a;
      pasm_vtx_type b;
      logic ptr;
      int n;
      n = vq.size();
      exp_q.delete();
      ptr = 1'b0;
      for (int i = 0; i < n; i++)
      begin
         case (m)
            3'h0: exp_q.push_back(mk(KIND_POINT, vq[i], '0, '0));
            3'h1, 3'h2:
               if (i > 0)
                  exp_q.push_back(mk(KIND_SEGMENT, vq[i-1], vq[i], '0));
            3'h3:
               if (i % 2 == 1)
                  exp_q.push_back(mk(KIND_SEGMENT, vq[i-1], vq[i], '0));
            3'h4, 3'h5:
            begin
               if (i > 1)
                  exp_q.push_back(mk(KIND_TRIANGLE, a, b, vq[i]));
               if (m == 3'h5 && i > 0)
                  b = vq[i];
               else if (!ptr)
                  a = vq[i];
               else
                  b = vq[i];
               ptr = !ptr;
            end
            3'h6:
               if (i % 3 == 2)
                  exp_q.push_back(mk(KIND_TRIANGLE, vq[i-2], vq[i-1],
                     vq[i]));
            default: ;
         endcase
      end
      if (m == 3'h2 && n > 1)
         exp_q.push_back(mk(KIND_SEGMENT, vq[n-1], vq[0], '0));
   endtask

   task automatic send(input pasm_vtx_type v, input logic last);
      int t;
      vtx_valid_i = 1'b1;
      vtx_data_i = v;
      vtx_last_i = last;
      t = 0;
      // Ready depends on draw start, which may have moved this time step
      #1;
      while (vtx_ready_o !== 1'b1)
      begin
         @(negedge sys_clk_i);
         t++;
         if (t > 500)
            timeout();
      end
      @(negedge sys_clk_i);
   endtask

   task automatic draw(input logic [2:0] m, input int n, input logic st);
      int t;
      vq.delete();
      for (int i = 0; i < n; i++)
         vq.push_back({$urandom, $urandom, $urandom, $urandom});
      build(m);
      i_sink.got_q.delete();
      hold = st;
      draw_mode_i = pasm_mode_type'(m);
      draw_start_i = 1'b1;
      #1;
      chk(vtx_ready_o, 1'b0);
      @(negedge sys_clk_i);
      draw_start_i = 1'b0;
      for (int i = 0; i < n; i++)
      begin
         send(vq[i], i == n - 1);
         if (st && i == 1)
         begin
            repeat (3) @(negedge sys_clk_i);
            // Two held primitives fill the buffer
            chk(vtx_ready_o, 1'b0);
            hold = 1'b0;
         end
      end
      vtx_valid_i = 1'b0;
      vtx_last_i = 1'b0;
      t = 0;
      while (i_sink.got_q.size() < exp_q.size() || prim_valid_o !== 1'b0)
      begin
         @(negedge sys_clk_i);
         t++;
         if (t > 600)
            timeout();
      end
      repeat (4) @(negedge sys_clk_i);
      chk(i_sink.got_q.size(), exp_q.size());
      for (int i = 0; i < exp_q.size() && i < i_sink.got_q.size(); i++)
         chk(i_sink.got_q[i], exp_q[i]);
   endtask

   function automatic pasm_vtx_type exp_attr(input logic it,
      input logic [1:0] nc, input pasm_vtx_type d);
      pasm_vtx_type r;
      r = ATTR_DEFAULT;
      if (it || nc == NCOMP_FOUR)
         return d;
      r[X_POS +: COMP_W] = d[X_POS +: COMP_W];
      if (nc >= NCOMP_TWO)
         r[Y_POS +: COMP_W] = d[Y_POS +: COMP_W];
      if (nc >= NCOMP_THREE)
         r[Z_POS +: COMP_W] = d[Z_POS +: COMP_W];
      return r;
   endfunction

   task automatic awr(input logic it, input logic [1:0] nc,
      input logic [7:0] s, input logic [1:0] c, input pasm_vtx_type d);
      attr_wr_i = 1'b1;
      attr_int_i = it;
      attr_ncomp_i = nc;
      attr_slot_i = s;
      attr_col_i = c;
      attr_data_i = d;
      @(negedge sys_clk_i);
      attr_wr_i = 1'b0;
      if (int'(s) + int'(c) < ATTR_SLOT_COUNT)
         mem[int'(s) + int'(c)] = exp_attr(it, nc, d);
      @(negedge sys_clk_i);
   endtask

   task automatic ard(input logic [7:0] s, input logic en,
      input pasm_vtx_type ad, input pasm_vtx_type e);
      attr_rd_slot_i = s;
      attr_array_en_i = en;
      attr_array_data_i = ad;
      @(negedge sys_clk_i);
      chk(attr_rd_data_o, e);
   endtask

   initial
   begin
      pasm_vtx_type r;
      seed = $urandom(32'ha982);
      repeat (2) @(posedge sys_clk_i);
      @(negedge sys_clk_i);
      reset_i = 1'b0;
      for (int s = 0; s < 16; s++)
      begin
         mem[s] = ATTR_DEFAULT;
         ard(s, 1'b0, '0, ATTR_DEFAULT);
      end
      chk({err_flag_o, err_code_o}, {1'b0, ERR_NONE});
      for (int i = 0; i < 24; i++)
      begin
         awr($urandom_range(1), $urandom_range(3), $urandom_range(12),
            $urandom_range(3), {$urandom, $urandom, $urandom, $urandom});
      end
      for (int c = 0; c < 4; c++)
         awr(1'b0, NCOMP_FOUR, 8'h0c, c, {$urandom, $urandom, 64'h0});
      for (int s = 0; s < 16; s++)
         ard(s, 1'b0, '0, mem[s]);
      r = {$urandom, $urandom, $urandom, $urandom};
      ard(8'h03, 1'b1, r, r);
      ard(8'h10, 1'b0, r, ATTR_DEFAULT);
      chk(err_flag_o, 1'b0);
      awr(1'b0, NCOMP_FOUR, 8'h0f, 2'h1, r);
      chk({err_flag_o, err_code_o}, {1'b1, ERR_BAD_VALUE});
      awr(1'b1, 2'h0, 8'hff, 2'h0, r);
      chk({err_flag_o, err_code_o}, {1'b1, ERR_BAD_VALUE});
      ard(8'h0f, 1'b0, '0, mem[15]);
      err_clear_i = 1'b1;
      @(negedge sys_clk_i);
      err_clear_i = 1'b0;
      chk({err_flag_o, err_code_o}, {1'b0, ERR_NONE});
      $display("attribute store test done");
      for (int m = 0; m < 8; m++)
         for (int n = 1; n < 8; n++)
            draw(m, n, 1'b0);
      $display("mode sweep test done");
      repeat (20) draw($urandom_range(6), $urandom_range(12, 1), 1'b0);
      $display("random draw test done");
      draw(3'h0, 6, 1'b1);
      draw(3'h4, 40, 1'b0);
      $display("stall and long draw test done");
      final_report();
   end
endmodule
`default_nettype wire
